// *** pkg/lcd_frame_pkg.sv ***
// Package with register map, field layout, reset values and helpers for the LCD frame timing block.
package lcd_frame_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] CLK_OFFSET = 12'h004;
  localparam logic [11:0] TIM_OFFSET = 12'h008;
  localparam logic [11:0] PWR_OFFSET = 12'h00C;
  localparam logic [11:0] STATUS_OFFSET = 12'h010;

  // Control register fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DISCHARGE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Clock register fields.
  localparam int CLK_SRC_LSB = 0;
  localparam int CLK_DIV_LSB = 4;
  localparam int CLK_RUN_DURING_DEBUG_BIT = 8;
  localparam logic [1:0] CLK_SRC_RESET = 2'h0;
  localparam logic [2:0] CLK_DIV_RESET = 3'h0;

  // Timing register fields.
  localparam int TIM_FRAME_LSB = 0;
  localparam int TIM_DUTY_LSB = 8;
  localparam logic [3:0] FRAME_COUNT_RESET = 4'h0;
  localparam logic [2:0] DUTY_RESET = 3'h0;

  // Power register fields.
  localparam int PWR_REG_BIT = 0;
  localparam int PWR_REF_BIT = 1;
  localparam int PWR_BOOST_BIT = 2;
  localparam int PWR_HEAVY_BIT = 3;
  localparam logic [3:0] PWR_RESET = 4'h0;

  // Status register fields.
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_SUSP_BIT = 1;
  localparam int STAT_FRAME_BIT = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_COUNT_LSB = 16;

  // Divider and shared-pin constants.
  localparam logic [11:0] FRAME_BASE_DIV = 12'h010;
  localparam int COUNT_WIDTH = 11;
  localparam logic [2:0] FIRST_SHARED_DUTY = 3'h4;

  // Drive voltage generation modes.
  typedef enum logic [1:0] {
    SUPPLY_EXT_ALL,
    SUPPLY_EXT_ONE,
    SUPPLY_REG_ONLY,
    SUPPLY_INTERNAL
  } supply_mode_e;

  // Frame period in operating clock ticks: 16 * (count + 1) * (duty + 1).
  function automatic logic [11:0] frame_period(input logic [3:0] fc, input logic [2:0] duty);
    logic [4:0] a;
    logic [3:0] b;
    logic [8:0] p;
    a = {1'b0, fc} + 5'h01;
    b = {1'b0, duty} + 4'h1;
    p = 9'({4'h0, a} * {5'h00, b});
    // Widen before the product so the longest period, 2048, does not wrap in nine bits.
    return {3'h0, p} * FRAME_BASE_DIV;
  endfunction

endpackage

// *** rtl/lcd_frame_divider.sv ***
// Frame divider counter producing the frame level and an end-of-frame pulse.
`timescale 1ns/1ps
module lcd_frame_divider #(
  parameter int CW = 11
) (
  input wire logic sys_clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic tick, // Operating clock enable pulse.
  input wire logic restart, // Force the counter and frame level to zero.
  input wire logic [3:0] frame_count, // Frame divide count.
  input wire logic [2:0] duty, // Drive duty select.
  output logic [CW-1:0] count, // Current divider count.
  output logic frame_level, // Frame signal, high in the first half.
  output logic frame_tick // One-cycle pulse at the frame end.
);

  logic [CW-1:0] count_reg, count_next;
  logic level_reg, level_next;
  logic tick_reg, tick_next;
  logic [11:0] period;
  logic [11:0] half;

  // Next count wraps at the programmed period; a restart wins over a tick.
  always_comb begin
    period = lcd_frame_pkg::frame_period(frame_count, duty);
    half = {1'b0, period[11:1]};
    count_next = count_reg;
    level_next = level_reg;
    tick_next = 1'b0;
    if (restart) begin
      count_next = '0;
      level_next = 1'b0;
    end else if (tick) begin
      if ({1'b0, count_reg} >= period - 12'h001) begin
        count_next = '0;
        tick_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
      level_next = ({1'b0, count_next} < half);
    end
  end

  // Registers only.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      count_reg <= '0;
      level_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      level_reg <= level_next;
      tick_reg <= tick_next;
    end
  end

  assign count = count_reg;
  assign frame_level = level_reg;
  assign frame_tick = tick_reg;

endmodule

// *** rtl/lcd_frame_timing_power_ctrl.sv ***
// Frame timing, debug clock gating and drive power control of a segment LCD driver.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module lcd_frame_timing_power_ctrl (
  input wire logic sys_clk, // System clock, 50 MHz.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write direction.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic op_clk_en, // Operating clock enable pulse.
  input wire logic debug_mode, // Processor is in debug mode.
  output logic [1:0] clock_source_select, // Operating clock source.
  output logic [2:0] clock_divide_select, // Operating clock division.
  output logic frame_monitor_out, // Frame monitor pin.
  output logic frame_tick, // End-of-frame pulse.
  output logic display_blank, // Display is blanked.
  output logic discharge_to_vss, // Pull driver pins to ground.
  output logic regulator_en, // Voltage regulator on.
  output logic booster_en, // Voltage booster on.
  output logic heavy_load_en, // Regulator heavy-load protection.
  output logic boost_ref_sel, // Boosting reference select.
  output lcd_frame_pkg::supply_mode_e supply_mode, // Drive voltage mode.
  output logic [7:0] common_active, // Common outputs carrying data.
  output logic [7:0] common_off_wave, // Common outputs forced to off waveform.
  output logic [3:0] shared_pin_is_common // Shared pins acting as commons.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [1:0] ctrl_reg, ctrl_next;
  logic [1:0] src_reg, src_next;
  logic [2:0] div_reg, div_next;
  logic run_during_debug_reg, run_during_debug_next;
  logic [3:0] frame_divide_count_reg, frame_divide_count_next;
  logic [2:0] drive_duty_select_reg, drive_duty_select_next;
  logic [3:0] pwr_reg, pwr_next;
  logic [31:0] prdata_reg, prdata_next;

  logic setup_phase;
  logic wr_access;
  logic addr_hit;
  logic tim_write;
  logic settings_change;
  logic suspended;
  logic driver_enable;
  logic tick_run;
  logic div_restart;
  logic [lcd_frame_pkg::COUNT_WIDTH-1:0] div_count;
  logic frame_level;

  // Address decode for the five mapped words.
  function automatic logic mapped(input logic [11:0] a);
    return (a == lcd_frame_pkg::CTRL_OFFSET) || (a == lcd_frame_pkg::CLK_OFFSET) ||
           (a == lcd_frame_pkg::TIM_OFFSET) || (a == lcd_frame_pkg::PWR_OFFSET) ||
           (a == lcd_frame_pkg::STATUS_OFFSET);
  endfunction

  // Read data is captured in the setup cycle so that the answer comes from a flop
  // with no wait state; the status word may therefore be one cycle old.
  assign setup_phase = psel && !penable;
  assign wr_access = psel && penable && pwrite && addr_hit;
  assign addr_hit = mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign tim_write = wr_access && (paddr == lcd_frame_pkg::TIM_OFFSET);

  // A timing write only restarts the divider if it really changes something.
  assign settings_change = tim_write &&
    ((pwdata[lcd_frame_pkg::TIM_FRAME_LSB +: 4] != frame_divide_count_reg) ||
     (pwdata[lcd_frame_pkg::TIM_DUTY_LSB +: 3] != drive_duty_select_reg));

  // Register writes stay allowed while suspended; the counting logic stops and the display blanks.
  always_comb begin
    ctrl_next = ctrl_reg;
    src_next = src_reg;
    div_next = div_reg;
    run_during_debug_next = run_during_debug_reg;
    frame_divide_count_next = frame_divide_count_reg;
    drive_duty_select_next = drive_duty_select_reg;
    pwr_next = pwr_reg;
    prdata_next = prdata_reg;
    if (wr_access) begin
      case (paddr)
        lcd_frame_pkg::CTRL_OFFSET: begin
          ctrl_next = pwdata[1:0];
        end
        lcd_frame_pkg::CLK_OFFSET: begin
          src_next = pwdata[lcd_frame_pkg::CLK_SRC_LSB +: 2];
          div_next = pwdata[lcd_frame_pkg::CLK_DIV_LSB +: 3];
          run_during_debug_next = pwdata[lcd_frame_pkg::CLK_RUN_DURING_DEBUG_BIT];
        end
        lcd_frame_pkg::TIM_OFFSET: begin
          frame_divide_count_next = pwdata[lcd_frame_pkg::TIM_FRAME_LSB +: 4];
          drive_duty_select_next = pwdata[lcd_frame_pkg::TIM_DUTY_LSB +: 3];
        end
        lcd_frame_pkg::PWR_OFFSET: begin
          pwr_next = pwdata[3:0];
        end
        default: begin
        end
      endcase
    end
    if (setup_phase) begin
      prdata_next = 32'h00000000;
      case (paddr)
        lcd_frame_pkg::CTRL_OFFSET: begin
          prdata_next[1:0] = ctrl_reg;
        end
        lcd_frame_pkg::CLK_OFFSET: begin
          prdata_next[lcd_frame_pkg::CLK_SRC_LSB +: 2] = src_reg;
          prdata_next[lcd_frame_pkg::CLK_DIV_LSB +: 3] = div_reg;
          prdata_next[lcd_frame_pkg::CLK_RUN_DURING_DEBUG_BIT] = run_during_debug_reg;
        end
        lcd_frame_pkg::TIM_OFFSET: begin
          prdata_next[lcd_frame_pkg::TIM_FRAME_LSB +: 4] = frame_divide_count_reg;
          prdata_next[lcd_frame_pkg::TIM_DUTY_LSB +: 3] = drive_duty_select_reg;
        end
        lcd_frame_pkg::PWR_OFFSET: begin
          prdata_next[3:0] = pwr_reg;
        end
        lcd_frame_pkg::STATUS_OFFSET: begin
          prdata_next[lcd_frame_pkg::STAT_RUN_BIT] = tick_run || (driver_enable && !suspended);
          prdata_next[lcd_frame_pkg::STAT_SUSP_BIT] = suspended;
          prdata_next[lcd_frame_pkg::STAT_FRAME_BIT] = frame_level;
          prdata_next[lcd_frame_pkg::STAT_MODE_LSB +: 2] = supply_mode;
          prdata_next[lcd_frame_pkg::STAT_COUNT_LSB +: lcd_frame_pkg::COUNT_WIDTH] = div_count;
        end
        default: begin
        end
      endcase
    end
  end

  // Register update.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_reg <= lcd_frame_pkg::CTRL_RESET;
      src_reg <= lcd_frame_pkg::CLK_SRC_RESET;
      div_reg <= lcd_frame_pkg::CLK_DIV_RESET;
      run_during_debug_reg <= 1'b0;
      frame_divide_count_reg <= lcd_frame_pkg::FRAME_COUNT_RESET;
      drive_duty_select_reg <= lcd_frame_pkg::DUTY_RESET;
      pwr_reg <= lcd_frame_pkg::PWR_RESET;
      prdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg <= ctrl_next;
      src_reg <= src_next;
      div_reg <= div_next;
      run_during_debug_reg <= run_during_debug_next;
      frame_divide_count_reg <= frame_divide_count_next;
      drive_duty_select_reg <= drive_duty_select_next;
      pwr_reg <= pwr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign clock_source_select = src_reg;
  assign clock_divide_select = div_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Operating clock gating and frame divider.

  // In debug with debug-run low the operating ticks are swallowed, which is the
  // enable-pulse form of stopping the clock; the divider simply freezes.
  assign driver_enable = ctrl_reg[lcd_frame_pkg::CTRL_ENABLE_BIT];
  assign suspended = debug_mode && !run_during_debug_reg;
  assign tick_run = op_clk_en && driver_enable && !suspended;
  assign div_restart = settings_change || !driver_enable;

  lcd_frame_divider #(
    .CW(lcd_frame_pkg::COUNT_WIDTH)
  ) lcd_frame_divider_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick(tick_run),
    .restart(div_restart),
    .frame_count(frame_divide_count_reg),
    .duty(drive_duty_select_reg),
    .count(div_count),
    .frame_level(frame_level),
    .frame_tick(frame_tick)
  );

  // The frame level comes straight from a divider flop and resets low.
  assign frame_monitor_out = frame_level;

  ////////////////////////////////////////////////////////////////////////////
  // Pin roles, blanking and power outputs.

  logic [7:0] active_reg, active_next;
  logic [7:0] off_reg, off_next;
  logic [3:0] shared_reg, shared_next;
  logic blank_reg, blank_next;
  logic discharge_reg, discharge_next;
  logic reg_en_reg, reg_en_next;
  logic boost_en_reg, boost_en_next;
  logic heavy_reg, heavy_next;
  logic ref_reg, ref_next;
  lcd_frame_pkg::supply_mode_e mode_reg, mode_next;

  // Heavy-load protection only has meaning while the regulator runs.
  always_comb begin
    blank_next = !driver_enable || suspended;
    discharge_next = blank_next && ctrl_reg[lcd_frame_pkg::CTRL_DISCHARGE_BIT];
    shared_next = {4{drive_duty_select_reg >= lcd_frame_pkg::FIRST_SHARED_DUTY}};
    for (int k = 0; k < 8; k++) begin
      active_next[k] = !blank_next && (3'(k) <= drive_duty_select_reg);
    end
    off_next[3:0] = ~active_next[3:0];
    off_next[7:4] = ~active_next[7:4] & shared_next;
    reg_en_next = pwr_reg[lcd_frame_pkg::PWR_REG_BIT];
    boost_en_next = pwr_reg[lcd_frame_pkg::PWR_BOOST_BIT];
    heavy_next = pwr_reg[lcd_frame_pkg::PWR_HEAVY_BIT] && pwr_reg[lcd_frame_pkg::PWR_REG_BIT];
    ref_next = pwr_reg[lcd_frame_pkg::PWR_REF_BIT];
    case ({pwr_reg[lcd_frame_pkg::PWR_REG_BIT], pwr_reg[lcd_frame_pkg::PWR_BOOST_BIT]})
      2'h3: mode_next = lcd_frame_pkg::SUPPLY_INTERNAL;
      2'h1: mode_next = lcd_frame_pkg::SUPPLY_EXT_ONE;
      2'h2: mode_next = lcd_frame_pkg::SUPPLY_REG_ONLY;
      default: mode_next = lcd_frame_pkg::SUPPLY_EXT_ALL;
    endcase
  end

  // Output registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      active_reg <= 8'h00;
      off_reg <= 8'hFF;
      shared_reg <= 4'h0;
      blank_reg <= 1'b1;
      discharge_reg <= 1'b0;
      reg_en_reg <= 1'b0;
      boost_en_reg <= 1'b0;
      heavy_reg <= 1'b0;
      ref_reg <= 1'b0;
      mode_reg <= lcd_frame_pkg::SUPPLY_EXT_ALL;
    end else begin
      active_reg <= active_next;
      off_reg <= off_next;
      shared_reg <= shared_next;
      blank_reg <= blank_next;
      discharge_reg <= discharge_next;
      reg_en_reg <= reg_en_next;
      boost_en_reg <= boost_en_next;
      heavy_reg <= heavy_next;
      ref_reg <= ref_next;
      mode_reg <= mode_next;
    end
  end

  assign common_active = active_reg;
  assign common_off_wave = off_reg;
  assign shared_pin_is_common = shared_reg;
  assign display_blank = blank_reg;
  assign discharge_to_vss = discharge_reg;
  assign regulator_en = reg_en_reg;
  assign booster_en = boost_en_reg;
  assign heavy_load_en = heavy_reg;
  assign boost_ref_sel = ref_reg;
  assign supply_mode = mode_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_frame_wrap: assert property (tick_run && !div_restart &&
    {1'b0, div_count} == lcd_frame_pkg::frame_period(frame_divide_count_reg, drive_duty_select_reg) - 12'h001
    |=> div_count == '0 && frame_tick)
    else $error("Divider did not wrap at the frame period.");

  a_count_range: assert property (
    {1'b0, div_count} < lcd_frame_pkg::frame_period(frame_divide_count_reg, drive_duty_select_reg))
    else $error("Divider count beyond frame period.");

  a_debug_freeze: assert property (debug_mode && !run_during_debug_reg && !div_restart
    |=> $stable(div_count) && !frame_tick)
    else $error("Divider moved while suspended for debug.");

  a_debug_blank: assert property (suspended && !wr_access
    |=> display_blank && $stable(pwr_reg) && $stable(frame_divide_count_reg))
    else $error("Suspend did not blank or lost register state.");

  a_debug_runs: assert property (debug_mode && run_during_debug_reg && op_clk_en && driver_enable &&
    !div_restart |=> div_count != $past(div_count))
    else $error("Divider stalled in debug with debug-run set.");

  a_supply_internal: assert property (pwr_reg[0] && pwr_reg[2] && $stable(pwr_reg)
    |=> regulator_en && booster_en && supply_mode == lcd_frame_pkg::SUPPLY_INTERNAL)
    else $error("Internal generation mode not entered.");

  a_supply_external: assert property (!pwr_reg[0] && !pwr_reg[2] && $stable(pwr_reg)
    |=> !regulator_en && !booster_en && supply_mode == lcd_frame_pkg::SUPPLY_EXT_ALL)
    else $error("External supply mode not entered.");

  a_supply_mixed: assert property (!pwr_reg[0] && pwr_reg[2] && $stable(pwr_reg)
    |=> !regulator_en && booster_en && supply_mode == lcd_frame_pkg::SUPPLY_EXT_ONE)
    else $error("Single external voltage mode not entered.");

  a_heavy_load: assert property (##1 heavy_load_en == ($past(pwr_reg[3]) && $past(pwr_reg[0])))
    else $error("Heavy-load output does not follow its bit.");

  a_ref_select: assert property (##1 boost_ref_sel == $past(pwr_reg[1]))
    else $error("Reference select does not follow its bit.");

  a_shared_role: assert property (##1 shared_pin_is_common == {4{$past(drive_duty_select_reg) >= 3'h4}})
    else $error("Shared pin role wrong for duty.");

  a_reset_low: assert property (disable iff (1'b0) srst |=> !frame_monitor_out)
    else $error("Frame monitor not low after reset.");

  a_unused_off: assert property (##1 !display_blank |-> common_active ==
    8'((9'h002 << $past(drive_duty_select_reg)) - 9'h001))
    else $error("Common enables do not match duty.");

  a_restart_zero: assert property (settings_change |=> div_count == '0 && !frame_monitor_out)
    else $error("Divider not restarted after setting change.");

endmodule

// *** bench/lcd_panel_model.sv ***
// Behavioural model of the passive LCD panel on the common lines.
`timescale 1ns/1ps
module lcd_panel_model (
  input wire logic sys_clk, // System clock.
  input wire logic [7:0] common_active, // Commons carrying data.
  input wire logic [7:0] common_off_wave, // Commons held at the off waveform.
  input wire logic discharge_to_vss, // Driver pins pulled to ground.
  output logic [7:0] lit_commons // Commons whose segments can light.
);
  logic [7:0] lit_reg;
  logic [7:0] lit_next;
  // A row lights only if its common carries data and is not held dark; grounded pins light nothing.
  always_comb begin
    lit_next = common_active & ~common_off_wave & {8{~discharge_to_vss}};
  end
  // The panel responds a cycle late, so checks must allow for the extra stage.
  always_ff @(posedge sys_clk) begin
    lit_reg <= lit_next;
  end
  assign lit_commons = lit_reg;
endmodule

// *** bench/lcd_frame_timing_power_ctrl_tb.sv ***
// Self-checking testbench for the LCD frame timing and power control block.
`timescale 1ns/1ps
module lcd_frame_timing_power_ctrl_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic op_clk_en = 1'b0;
  logic debug_mode = 1'b0;
  logic [1:0] tick_div = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, frame_monitor_out, frame_tick, display_blank, discharge_to_vss;
  logic regulator_en, booster_en, heavy_load_en, boost_ref_sel;
  logic [1:0] clock_source_select;
  logic [2:0] clock_divide_select;
  lcd_frame_pkg::supply_mode_e supply_mode;
  logic [7:0] common_active, common_off_wave, lit_commons;
  logic [3:0] shared_pin_is_common;
  int n_mismatch = 0;
  int total_checks = 0;

  lcd_frame_timing_power_ctrl lcd_frame_timing_power_ctrl_inst (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .op_clk_en, .debug_mode, .clock_source_select, .clock_divide_select,
    .frame_monitor_out, .frame_tick, .display_blank, .discharge_to_vss, .regulator_en, .booster_en, .heavy_load_en,
    .boost_ref_sel, .supply_mode, .common_active, .common_off_wave, .shared_pin_is_common);
  lcd_panel_model lcd_panel_model_inst (.sys_clk, .common_active, .common_off_wave, .discharge_to_vss, .lit_commons);

  // Clock and operating tick; the tick runs every fourth cycle, far above 32 kHz, to keep frames short.
  // The tick never stops, as if the oscillator were kept running through sleep.
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick_div <= tick_div + 2'h1;
    op_clk_en <= (tick_div == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, act, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    check_val(r, exp);
    check_val({31'h0, e}, {31'h0, exp_err});
  endtask
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Counts ticks, and ticks seen with the monitor high, up to the next frame pulse.
  task automatic measure(output int t, output int h);
    t = 0;
    h = 0;
    do begin
      @(posedge sys_clk);
      #1;
      if (op_clk_en === 1'b1) t++;
      if (op_clk_en === 1'b1 && frame_monitor_out === 1'b1) h++;
    end while (frame_tick !== 1'b1);
  endtask
  task automatic frame_check(input int p);
    int t, h;
    measure(t, h);
    measure(t, h);
    check_val(32'(t), 32'(p));
    check_val(32'(h), 32'(p / 2));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    #1;
    check_val({31'h0, frame_monitor_out}, 32'h0);
    check_val({31'h0, display_blank}, 32'h1);
    check_val({24'h0, common_off_wave}, 32'hFF);
    check_val({30'h0, supply_mode}, 32'h0);
    rd_check(lcd_frame_pkg::TIM_OFFSET, 32'h0, 1'b0);
    rd_check(lcd_frame_pkg::PWR_OFFSET, 32'h0, 1'b0);
    rd_check(12'h020, 32'h0, 1'b1);
    wr(lcd_frame_pkg::CTRL_OFFSET, 32'h00000002);
    wr(lcd_frame_pkg::CLK_OFFSET, 32'h00000053);
    settle();
    check_val({31'h0, discharge_to_vss}, 32'h1);
    check_val({27'h0, clock_divide_select, clock_source_select}, 32'h17);
  endtask
  task automatic t_power();
    logic [3:0] b;
    for (int i = 0; i < 16; i++) begin
      b = 4'(i);
      wr(lcd_frame_pkg::PWR_OFFSET, {28'h0, b});
      settle();
      check_val({30'h0, regulator_en, booster_en}, {30'h0, b[0], b[2]});
      check_val({30'h0, supply_mode}, {30'h0, b[0], b[2]});
      check_val({31'h0, heavy_load_en}, {31'h0, b[3] & b[0]});
      check_val({31'h0, boost_ref_sel}, {31'h0, b[1]});
    end
    // Driver still disabled here, so the status word holds only the internal supply mode.
    rd_check(lcd_frame_pkg::STATUS_OFFSET, 32'h00000030, 1'b0);
  endtask
  task automatic t_duty();
    logic [7:0] act;
    logic [3:0] sh;
    wr(lcd_frame_pkg::CTRL_OFFSET, 32'h00000003);
    for (int d = 0; d < 8; d++) begin
      act = 8'((16'h0002 << d) - 16'h0001);
      sh = (d >= 4) ? 4'hF : 4'h0;
      wr(lcd_frame_pkg::TIM_OFFSET, 32'(d) << 8);
      settle();
      check_val({24'h0, common_active}, {24'h0, act});
      check_val({24'h0, common_off_wave}, {24'h0, ~act[7:4] & sh, ~act[3:0]});
      check_val({28'h0, shared_pin_is_common}, {28'h0, sh});
      check_val({24'h0, lit_commons}, {24'h0, act});
      frame_check(16 * (d + 1));
    end
    wr(lcd_frame_pkg::TIM_OFFSET, 32'h0000010F);
    frame_check(512);
  endtask
  task automatic t_debug();
    int n;
    wr(lcd_frame_pkg::TIM_OFFSET, 32'h00000002);
    @(posedge sys_clk);
    debug_mode <= 1'b1;
    settle();
    check_val({31'h0, display_blank}, 32'h1);
    check_val({24'h0, common_active}, 32'h0);
    n = 0;
    repeat (300) begin
      @(posedge sys_clk);
      #1;
      if (frame_tick === 1'b1) n++;
    end
    check_val(32'(n), 32'h0);
    rd_check(lcd_frame_pkg::TIM_OFFSET, 32'h00000002, 1'b0);
    @(posedge sys_clk);
    debug_mode <= 1'b0;
    frame_check(48);
    wr(lcd_frame_pkg::CLK_OFFSET, 32'h00000100);
    @(posedge sys_clk);
    debug_mode <= 1'b1;
    frame_check(48);
    check_val({31'h0, display_blank}, 32'h0);
    @(posedge sys_clk);
    debug_mode <= 1'b0;
  endtask
  // Retiming just after a tick keeps the store edge clear of the next tick.
  task automatic t_restart();
    int t, h;
    wr(lcd_frame_pkg::TIM_OFFSET, 32'h00000103);
    measure(t, h);
    repeat (160) @(posedge sys_clk);
    do begin
      @(posedge sys_clk);
      #1;
    end while (op_clk_en !== 1'b1);
    wr(lcd_frame_pkg::TIM_OFFSET, 32'h00000101);
    @(posedge sys_clk);
    #1;
    check_val({31'h0, frame_monitor_out}, 32'h0);
    measure(t, h);
    check_val(32'(t + 1), 32'h40);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run through the same verdict.
  initial begin
    repeat (60000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_power();
    t_duty();
    t_debug();
    t_restart();
    tally_and_finish();
  end
endmodule
